// ===== hdl/japr_engine.sv
module japr_engine (
	// Clock and reset
	input wire logic mclk_in,
	input wire logic rstn_in,
	// Command side
	input wire logic cmd_valid_in,
	input wire logic [7:0] cmd_data_in,
	output logic cmd_ready_out,
	// Response side
	output logic rsp_valid_out,
	output logic [7:0] rsp_data_out,
	input wire logic rsp_ready_in,
	// Scan lines
	input wire logic tdo_in,
	output logic tck_out,
	output logic tms_out,
	output logic tdi_out,
	// Status
	output logic idle_out
);

	japr_pkg::japr_eng_state_type state;
	logic [3:0] div;
	logic [2:0] bit_idx;
	logic [7:0] tx;
	logic [7:0] rx;

	assign cmd_ready_out = (state == japr_pkg::ENG_IDLE);
	assign rsp_valid_out = (state == japr_pkg::ENG_PUSH);
	assign rsp_data_out = rx;
	assign idle_out = (state == japr_pkg::ENG_IDLE);
	assign tms_out = 1'b0;

	// ------------------------------------------------------------
	// Byte shifter, LSB first, sample on rising clock
	// ------------------------------------------------------------
	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			state <= japr_pkg::ENG_IDLE;
			div <= 4'h0;
			bit_idx <= 3'h0;
			tx <= 8'h00;
			rx <= 8'h00;
			tck_out <= 1'b0;
			tdi_out <= 1'b0;
		end else begin
			case (state)
				japr_pkg::ENG_IDLE: begin
					tck_out <= 1'b0;
					if (cmd_valid_in) begin
						tx <= cmd_data_in;
						tdi_out <= cmd_data_in[0];
						bit_idx <= 3'h0;
						div <= 4'h0;
						state <= japr_pkg::ENG_SHIFT;
					end
				end
				japr_pkg::ENG_SHIFT: begin
					if (div == japr_pkg::TCK_HALF_CYCLES - 4'h1) begin
						div <= 4'h0;
						if (!tck_out) begin
							tck_out <= 1'b1;
							rx[bit_idx] <= tdo_in;
						end else begin
							tck_out <= 1'b0;
							if (bit_idx == 3'h7) begin
								state <= japr_pkg::ENG_PUSH;
							end else begin
								bit_idx <= bit_idx + 3'h1;
								tdi_out <= tx[bit_idx + 3'h1];
							end
						end
					end else begin
						div <= div + 4'h1;
					end
				end
				japr_pkg::ENG_PUSH: begin
					if (rsp_ready_in) begin
						state <= japr_pkg::ENG_IDLE;
					end
				end
				default: begin
					state <= japr_pkg::ENG_IDLE;
				end
			endcase
		end
	end

endmodule : japr_engine

// ===== hdl/japr_pkg.sv
// Behaviour
// - Engine-active sets on first command taken, clears when queue empty and idle.
// - Command queue count field shows waiting command bytes, zero to four.
// - Response queue count field shows held response bytes, zero to seven.
// - Status bit is AND of attached inputs of all selected ports.
// - Status bit is AND of system-reset-attached inputs of selected ports.
// - Test reset bit drives active-low test reset of usable ports; never self-clears.
// - System reset bit drives active-low system reset of usable ports; software clears.
// - A select bit enables a port only when attached and powered.
// - Eight select bits, bit n selects port n.
// - Selected attached port losing power sets its fault bit three cycles later, after the two-stage input synchroniser.
// - Fault bit stays set until software writes one or an abort occurs.
// - Deselecting a port leaves its fault bit unchanged.
// - Faulted port is disabled; its clock, mode and data outputs held low.
// - Four queue registers move one to four bytes; writes push, reads pop.
// - Identity word holds revision, continuation code and identification code.
// - In integration mode abort rising edge latches status; reading clears it.
// - Abort rising edge coinciding with a status read loses; the bit clears.
// - Outside integration mode the abort status reads zero, writes ignored.
// - Integration mode is active while the integration-enable bit is one.
package japr_pkg;

	// ------------------------------------------------------------
	// Register offsets
	// ------------------------------------------------------------
	localparam logic [11:0] OFS_CST = 12'hd00;
	localparam logic [11:0] OFS_SEL = 12'hd04;
	localparam logic [11:0] OFS_FLT = 12'hd08;
	localparam logic [11:0] OFS_BQ_ONE = 12'hd10;
	localparam logic [11:0] OFS_BQ_TWO = 12'hd14;
	localparam logic [11:0] OFS_BQ_THREE = 12'hd18;
	localparam logic [11:0] OFS_BQ_FOUR = 12'hd1c;
	localparam logic [11:0] OFS_IDW = 12'hdfc;
	localparam logic [11:0] OFS_ABT = 12'hefc;
	localparam logic [11:0] OFS_ITM = 12'hf00;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int CST_ACTIVE_BIT = 31;
	localparam int CST_CMDCNT_LSB = 28;
	localparam int CST_RSPCNT_LSB = 24;
	localparam int CST_ATTACH_BIT = 3;
	localparam int CST_SRSTATT_BIT = 2;
	localparam int CST_TRST_BIT = 1;
	localparam int CST_SRST_BIT = 0;
	localparam int IDW_REV_LSB = 28;
	localparam int IDW_CONT_LSB = 24;
	localparam int IDW_CODE_LSB = 17;
	localparam int ABT_FLAG_BIT = 0;
	localparam int ITM_ENABLE_BIT = 0;

	// ------------------------------------------------------------
	// Reset values and sizes
	// ------------------------------------------------------------
	localparam logic [1:0] CST_CTRL_RESET = 2'h0;
	localparam logic [7:0] SEL_RESET = 8'h00;
	localparam logic [7:0] FLT_RESET = 8'h00;
	localparam logic ABT_RESET = 1'h0;
	localparam logic ITM_RESET = 1'h0;
	localparam int NUM_PORTS = 8;
	localparam int CMD_DEPTH = 4;
	localparam int RSP_DEPTH = 7;
	localparam int SYNC_WIDTH = 4 * NUM_PORTS + 1;

	// ------------------------------------------------------------
	// Timing: link clock half period in system clocks
	// ------------------------------------------------------------
	localparam logic [3:0] TCK_HALF_CYCLES = 4'h4;

	// ------------------------------------------------------------
	// Engine states
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		ENG_IDLE = 2'b00,
		ENG_SHIFT = 2'b01,
		ENG_PUSH = 2'b10
	} japr_eng_state_type;

	// Wrapping index step for the byte queues
	function automatic logic [2:0] next_index(input logic [2:0] idx,
		input logic [2:0] depth);
		next_index = (idx == depth - 3'h1) ? 3'h0 : idx + 3'h1;
	endfunction : next_index

endpackage : japr_pkg

// ===== hdl/japr_queue.sv
module japr_queue #(
	parameter logic [2:0] DEPTH = 3'h4
) (
	// Clock and reset
	input wire logic mclk_in,
	input wire logic rstn_in,
	// Fill side
	input wire logic in_valid_in,
	input wire logic [7:0] in_data_in,
	output logic in_ready_out,
	// Drain side
	output logic out_valid_out,
	output logic [7:0] out_data_out,
	input wire logic out_ready_in,
	// Occupancy
	output logic [2:0] count_out
);

	logic [7:0] store [0:6];
	logic [2:0] wr_idx;
	logic [2:0] rd_idx;
	logic [2:0] count;
	logic do_push;
	logic do_pop;

	assign in_ready_out = (count != DEPTH);
	assign out_valid_out = (count != 3'h0);
	assign out_data_out = store[rd_idx];
	assign count_out = count;
	assign do_push = in_valid_in & in_ready_out;
	assign do_pop = out_valid_out & out_ready_in;

	// ------------------------------------------------------------
	// Storage
	// ------------------------------------------------------------
	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			for (int i = 0; i < 7; i++) begin
				store[i] <= 8'h00;
			end
		end else if (do_push) begin
			store[wr_idx] <= in_data_in;
		end
	end

	// ------------------------------------------------------------
	// Pointers and count
	// ------------------------------------------------------------
	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			wr_idx <= 3'h0;
			rd_idx <= 3'h0;
			count <= 3'h0;
		end else begin
			if (do_push) begin
				wr_idx <= japr_pkg::next_index(wr_idx, DEPTH);
			end
			if (do_pop) begin
				rd_idx <= japr_pkg::next_index(rd_idx, DEPTH);
			end
			if (do_push && !do_pop) begin
				count <= count + 3'h1;
			end else if (do_pop && !do_push) begin
				count <= count - 3'h1;
			end
		end
	end

endmodule : japr_queue

// ===== hdl/japr_regs.sv
module japr_regs #(
	// Arbitrary identity values
	parameter logic [3:0] ID_REVISION = 4'h0,
	parameter logic [3:0] ID_CONTINUATION = 4'h1,
	parameter logic [6:0] ID_CODE = 7'h55
) (
	// Clock and reset
	input wire logic mclk_in,
	input wire logic rstn_in,
	// Register bus
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [11:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	input wire logic [3:0] pstrb_in,
	output logic pready_out,
	output logic [31:0] prdata_out,
	output logic pslverr_out,
	// Slave port status
	input wire logic [7:0] port_connected_in,
	input wire logic [7:0] port_enabled_in,
	input wire logic [7:0] srst_connected_in,
	input wire logic [7:0] tdo_in,
	// Slave port drive
	output logic [7:0] tck_out,
	output logic [7:0] tms_out,
	output logic [7:0] tdi_out,
	output logic [7:0] test_reset_n_out,
	output logic [7:0] sys_reset_n_out,
	// Abort
	input wire logic debug_port_abort_in
);

	// ------------------------------------------------------------
	// Input synchronisers
	// ------------------------------------------------------------
	logic [japr_pkg::SYNC_WIDTH-1:0] sync1;
	logic [japr_pkg::SYNC_WIDTH-1:0] sync2;
	logic abort_prev;
	logic [7:0] conn_s;
	logic [7:0] enab_s;
	logic [7:0] srst_s;
	logic [7:0] tdo_s;
	logic abort_s;
	logic abort_rise;

	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			sync1 <= '0;
			sync2 <= '0;
			abort_prev <= 1'b0;
		end else begin
			sync1 <= {debug_port_abort_in, tdo_in, srst_connected_in,
				port_enabled_in, port_connected_in};
			sync2 <= sync1;
			abort_prev <= abort_s;
		end
	end

	assign conn_s = sync2[7:0];
	assign enab_s = sync2[15:8];
	assign srst_s = sync2[23:16];
	assign tdo_s = sync2[31:24];
	assign abort_s = sync2[32];
	assign abort_rise = abort_s & ~abort_prev;

	// ------------------------------------------------------------
	// Bus decode
	// ------------------------------------------------------------
	logic setup;
	logic access;
	logic is_queue;
	logic [2:0] last_byte;
	logic [2:0] xfer_cnt;
	logic xfer_done;
	logic reg_write;
	logic abort_read;

	assign setup = psel_in & ~penable_in;
	assign access = psel_in & penable_in;
	assign is_queue = (paddr_in[11:4] == japr_pkg::OFS_BQ_ONE[11:4]);
	assign last_byte = {1'b0, paddr_in[3:2]};
	assign xfer_done = (xfer_cnt == last_byte + 3'h1);
	assign pready_out = ~is_queue | xfer_done;
	assign pslverr_out = 1'b0;
	assign reg_write = access & pwrite_in & ~is_queue;
	assign abort_read = setup & ~pwrite_in &
		(paddr_in == japr_pkg::OFS_ABT);

	// ------------------------------------------------------------
	// Queues and engine
	// ------------------------------------------------------------
	logic cmd_push_valid;
	logic cmd_push_ready;
	logic [7:0] cmd_push_data;
	logic cmd_valid;
	logic cmd_ready;
	logic [7:0] cmd_data;
	logic [2:0] cmd_count;
	logic rsp_push_valid;
	logic rsp_push_ready;
	logic [7:0] rsp_push_data;
	logic rsp_pop_valid;
	logic rsp_pop_ready;
	logic [7:0] rsp_pop_data;
	logic [2:0] rsp_count;
	logic eng_idle;
	logic eng_tck;
	logic eng_tms;
	logic eng_tdi;
	logic eng_tdo;
	logic byte_moved;

	assign cmd_push_valid = access & pwrite_in & is_queue & ~xfer_done;
	assign cmd_push_data = pwdata_in[{xfer_cnt[1:0], 3'h0} +: 8];
	assign rsp_pop_ready = access & ~pwrite_in & is_queue & ~xfer_done;
	assign byte_moved = (cmd_push_valid & cmd_push_ready) |
		(rsp_pop_valid & rsp_pop_ready);

	japr_queue #(
		.DEPTH(3'(japr_pkg::CMD_DEPTH))
	) u_cmd_queue (
		.mclk_in(mclk_in),
		.rstn_in(rstn_in),
		.in_valid_in(cmd_push_valid),
		.in_data_in(cmd_push_data),
		.in_ready_out(cmd_push_ready),
		.out_valid_out(cmd_valid),
		.out_data_out(cmd_data),
		.out_ready_in(cmd_ready),
		.count_out(cmd_count)
	);

	japr_queue #(
		.DEPTH(3'(japr_pkg::RSP_DEPTH))
	) u_rsp_queue (
		.mclk_in(mclk_in),
		.rstn_in(rstn_in),
		.in_valid_in(rsp_push_valid),
		.in_data_in(rsp_push_data),
		.in_ready_out(rsp_push_ready),
		.out_valid_out(rsp_pop_valid),
		.out_data_out(rsp_pop_data),
		.out_ready_in(rsp_pop_ready),
		.count_out(rsp_count)
	);

	japr_engine u_engine (
		.mclk_in(mclk_in),
		.rstn_in(rstn_in),
		.cmd_valid_in(cmd_valid),
		.cmd_data_in(cmd_data),
		.cmd_ready_out(cmd_ready),
		.rsp_valid_out(rsp_push_valid),
		.rsp_data_out(rsp_push_data),
		.rsp_ready_in(rsp_push_ready),
		.tdo_in(eng_tdo),
		.tck_out(eng_tck),
		.tms_out(eng_tms),
		.tdi_out(eng_tdi),
		.idle_out(eng_idle)
	);

	// ------------------------------------------------------------
	// Byte transfer counter
	// ------------------------------------------------------------
	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			xfer_cnt <= 3'h0;
		end else if (access && is_queue && xfer_done) begin
			xfer_cnt <= 3'h0;
		end else if (byte_moved) begin
			xfer_cnt <= xfer_cnt + 3'h1;
		end
	end

	// ------------------------------------------------------------
	// Control registers
	// ------------------------------------------------------------
	logic trst_bit;
	logic srst_bit;
	logic [7:0] port_select;
	logic integration_enable;
	logic engine_active;

	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			{trst_bit, srst_bit} <= japr_pkg::CST_CTRL_RESET;
		end else if (reg_write && pstrb_in[0] &&
			paddr_in == japr_pkg::OFS_CST) begin
			trst_bit <= pwdata_in[japr_pkg::CST_TRST_BIT];
			srst_bit <= pwdata_in[japr_pkg::CST_SRST_BIT];
		end
	end

	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			port_select <= japr_pkg::SEL_RESET;
		end else if (reg_write && pstrb_in[0] &&
			paddr_in == japr_pkg::OFS_SEL) begin
			port_select <= pwdata_in[7:0];
		end
	end

	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			integration_enable <= japr_pkg::ITM_RESET;
		end else if (reg_write && pstrb_in[0] &&
			paddr_in == japr_pkg::OFS_ITM) begin
			integration_enable <= pwdata_in[japr_pkg::ITM_ENABLE_BIT];
		end
	end

	// ------------------------------------------------------------
	// Engine activity
	// ------------------------------------------------------------
	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			engine_active <= 1'b0;
		end else if (cmd_valid && cmd_ready) begin
			engine_active <= 1'b1;
		end else if (cmd_count == 3'h0 && eng_idle) begin
			engine_active <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Port faults
	// ------------------------------------------------------------
	logic [7:0] port_fault;
	logic [7:0] fault_set;
	logic [7:0] fault_clr;

	assign fault_set = port_select & conn_s & ~enab_s;
	assign fault_clr = ((reg_write && pstrb_in[0] &&
		paddr_in == japr_pkg::OFS_FLT) ? pwdata_in[7:0] : 8'h00) |
		(abort_rise ? 8'hff : 8'h00);

	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			port_fault <= japr_pkg::FLT_RESET;
		end else begin
			// Set wins over clear; selection plays no part in clearing
			port_fault <= (port_fault & ~fault_clr) | fault_set;
		end
	end

	// ------------------------------------------------------------
	// Abort status
	// ------------------------------------------------------------
	logic abort_status;

	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			abort_status <= japr_pkg::ABT_RESET;
		end else if (!integration_enable) begin
			abort_status <= 1'b0;
		end else if (abort_read) begin
			abort_status <= 1'b0;
		end else if (abort_rise) begin
			abort_status <= 1'b1;
		end
	end

	// ------------------------------------------------------------
	// Port drive
	// ------------------------------------------------------------
	logic [7:0] port_on;
	logic [7:0] drive_ok;
	logic all_selected_attached;
	logic all_sysreset_attached;

	assign drive_ok = port_select & conn_s & ~port_fault;
	assign port_on = drive_ok & enab_s;
	assign tck_out = {8{eng_tck}} & port_on;
	assign tms_out = {8{eng_tms}} & port_on;
	assign tdi_out = {8{eng_tdi}} & port_on;
	assign eng_tdo = |(tdo_s & port_on);
	assign test_reset_n_out = ~({8{trst_bit}} & drive_ok);
	assign sys_reset_n_out = ~({8{srst_bit}} & drive_ok);
	assign all_selected_attached = &(conn_s | ~port_select);
	assign all_sysreset_attached = &(srst_s | ~port_select);

	// ------------------------------------------------------------
	// Read data
	// ------------------------------------------------------------
	logic [31:0] rdata;
	logic [31:0] next_rdata;

	always_comb begin
		next_rdata = 32'h00000000;
		case (paddr_in)
			japr_pkg::OFS_CST: begin
				next_rdata[japr_pkg::CST_ACTIVE_BIT] = engine_active;
				next_rdata[japr_pkg::CST_CMDCNT_LSB +: 3] = cmd_count;
				next_rdata[japr_pkg::CST_RSPCNT_LSB +: 3] = rsp_count;
				next_rdata[japr_pkg::CST_ATTACH_BIT] = all_selected_attached;
				next_rdata[japr_pkg::CST_SRSTATT_BIT] = all_sysreset_attached;
				next_rdata[japr_pkg::CST_TRST_BIT] = trst_bit;
				next_rdata[japr_pkg::CST_SRST_BIT] = srst_bit;
			end
			japr_pkg::OFS_SEL: begin
				next_rdata[7:0] = port_select;
			end
			japr_pkg::OFS_FLT: begin
				next_rdata[7:0] = port_fault;
			end
			japr_pkg::OFS_IDW: begin
				next_rdata[japr_pkg::IDW_REV_LSB +: 4] = ID_REVISION;
				next_rdata[japr_pkg::IDW_CONT_LSB +: 4] = ID_CONTINUATION;
				next_rdata[japr_pkg::IDW_CODE_LSB +: 7] = ID_CODE;
			end
			japr_pkg::OFS_ABT: begin
				next_rdata[japr_pkg::ABT_FLAG_BIT] =
					abort_status & integration_enable;
			end
			japr_pkg::OFS_ITM: begin
				next_rdata[japr_pkg::ITM_ENABLE_BIT] = integration_enable;
			end
			default: begin
				next_rdata = 32'h00000000;
			end
		endcase
	end

	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			rdata <= 32'h00000000;
		end else if (setup && !pwrite_in) begin
			rdata <= is_queue ? 32'h00000000 : next_rdata;
		end else if (rsp_pop_valid && rsp_pop_ready) begin
			rdata[{xfer_cnt[1:0], 3'h0} +: 8] <= rsp_pop_data;
		end
	end

	assign prdata_out = rdata;

endmodule : japr_regs

// ===== verification/japr_regs_monitor.sv
module japr_regs_monitor #(
	parameter logic [3:0] ID_REVISION = 4'h0,
	parameter logic [3:0] ID_CONTINUATION = 4'h1,
	parameter logic [6:0] ID_CODE = 7'h55
) (
	// Clock, reset and bus
	input wire logic mclk_in,
	input wire logic rstn_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [11:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	input wire logic [3:0] pstrb_in,
	input wire logic pready_out,
	input wire logic [31:0] prdata_out,
	// Port lines
	input wire logic [7:0] port_connected_in,
	input wire logic [7:0] port_enabled_in,
	input wire logic [7:0] tck_out,
	input wire logic [7:0] tdi_out,
	input wire logic [7:0] test_reset_n_out,
	input wire logic [7:0] sys_reset_n_out
);
	default clocking @(posedge mclk_in); endclocking
	default disable iff (!rstn_in);
	// ----------------------------------------
	// Shadows of written registers
	// ----------------------------------------
	logic [7:0] sel_shadow;
	logic ie_shadow;
	logic wr_ok;
	assign wr_ok = psel_in && penable_in && pwrite_in && pready_out
		&& pstrb_in[0];
	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			sel_shadow <= 8'h00;
		end else if (wr_ok && paddr_in == japr_pkg::OFS_SEL) begin
			sel_shadow <= pwdata_in[7:0];
		end
	end
	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			ie_shadow <= 1'b0;
		end else if (wr_ok && paddr_in == japr_pkg::OFS_ITM) begin
			ie_shadow <= pwdata_in[0];
		end
	end
	// ----------------------------------------
	// Checks
	// ----------------------------------------
	sequence s_read(logic [11:0] a);
		psel_in && !penable_in && !pwrite_in && paddr_in == a ##1 penable_in;
	endsequence
	a_select_readback: assert property (s_read(japr_pkg::OFS_SEL)
		|-> prdata_out == {24'h0, sel_shadow}) else $error("select readback");
	a_ident_word_fixed: assert property (s_read(japr_pkg::OFS_IDW)
		|-> prdata_out == {ID_REVISION, ID_CONTINUATION, ID_CODE, 17'h0})
		else $error("identity word wrong");
	a_abort_off_zero: assert property (s_read(japr_pkg::OFS_ABT)
		##0 !ie_shadow |-> !prdata_out[0]) else $error("abort bit not zero");
	a_cmd_count_cap: assert property (s_read(japr_pkg::OFS_CST)
		|-> prdata_out[30:28] <= 3'h4) else $error("command count too big");
	a_reg_no_wait: assert property (psel_in && penable_in
		&& paddr_in[11:4] != 8'hd1 |-> pready_out) else $error("register wait");
	a_queue_write_len: assert property (psel_in && !penable_in
		&& pwrite_in && paddr_in == japr_pkg::OFS_BQ_FOUR ##1 penable_in
		|-> !pready_out [*4]) else $error("four byte write too short");
	a_unpowered_quiet: assert property ($fell(port_enabled_in[0])
		|-> ##4 (tck_out[0] == 1'b0 && tdi_out[0] == 1'b0) [*3])
		else $error("unpowered port still driven");
	a_trst_released: assert property (!port_connected_in[0] [*4]
		|-> test_reset_n_out[0]) else $error("test reset on detached port");
	a_srst_released: assert property (!port_connected_in[0] [*4]
		|-> sys_reset_n_out[0]) else $error("system reset on detached port");
endmodule : japr_regs_monitor

bind japr_regs japr_regs_monitor #(.ID_REVISION(ID_REVISION),
	.ID_CONTINUATION(ID_CONTINUATION), .ID_CODE(ID_CODE)) u_monitor (
	.mclk_in, .rstn_in, .psel_in, .penable_in, .pwrite_in, .paddr_in,
	.pwdata_in, .pstrb_in, .pready_out, .prdata_out, .port_connected_in,
	.port_enabled_in, .tck_out, .tdi_out, .test_reset_n_out,
	.sys_reset_n_out);

// ===== verification/japr_slave_model.sv
module japr_slave_model (
	// Bench controls
	input wire logic [7:0] attach_ctl_in,
	input wire logic [7:0] power_ctl_in,
	input wire logic [7:0] srst_ctl_in,
	// Scan lines from the block
	input wire logic [7:0] tck_in,
	input wire logic [7:0] tdi_in,
	// Lines to the block
	output logic [7:0] port_connected_out,
	output logic [7:0] port_enabled_out,
	output logic [7:0] srst_connected_out,
	output logic [7:0] tdo_out,
	output int rise_count_out
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] capture;
	assign port_connected_out = attach_ctl_in;
	assign port_enabled_out = power_ctl_in;
	assign srst_connected_out = srst_ctl_in;
	initial begin
		capture = 8'h00;
		tdo_out = 8'h00;
		rise_count_out = 0;
	end
	// One-bit bypass stage: capture on rise, present on fall
	for (genvar n = 0; n < 8; n++) begin : g_port
		always @(posedge tck_in[n]) capture[n] <= tdi_in[n];
		always @(negedge tck_in[n]) tdo_out[n] <= capture[n];
	end
	always @(posedge tck_in[0]) rise_count_out <= rise_count_out + 1;
endmodule : japr_slave_model

// ===== verification/test_jtag_access_port_regs.sv
`define CHK(nm, ex, gt) begin checked++; if ((gt) !== (ex)) begin \
	miscompares++; $display("MISMATCH %s exp %h got %h", nm, ex, gt); end end
module test_jtag_access_port_regs;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [3:0] REV = 4'h2; // Arbitrary identity values
	localparam logic [3:0] CONT = 4'h9;
	localparam logic [6:0] CODE = 7'h2a;
	logic mclk_in = 1'b0, rstn_in = 1'b0, psel = 1'b0, penable = 1'b0;
	logic pwrite = 1'b0, abort = 1'b0, carry = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata;
	logic [3:0] pstrb = 4'hf;
	logic [7:0] att = 8'hff, pwr = 8'hff, srs = 8'hff, sel;
	logic [7:0] conn, pen, sc, tdo, tck, tms, tdi, trst_n, sysr_n;
	logic pready;
	logic [7:0] rq[$];
	int checked = 0, miscompares = 0, cycles = 0, rises, seed = 4556;
	japr_regs #(.ID_REVISION(REV), .ID_CONTINUATION(CONT), .ID_CODE(CODE))
		uut (.mclk_in(mclk_in), .rstn_in(rstn_in), .psel_in(psel),
		.penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
		.pwdata_in(pwdata), .pstrb_in(pstrb), .pready_out(pready),
		.prdata_out(prdata), .pslverr_out(), .port_connected_in(conn),
		.port_enabled_in(pen), .srst_connected_in(sc), .tdo_in(tdo),
		.tck_out(tck), .tms_out(tms), .tdi_out(tdi),
		.test_reset_n_out(trst_n), .sys_reset_n_out(sysr_n),
		.debug_port_abort_in(abort));
	japr_slave_model slave (.attach_ctl_in(att), .power_ctl_in(pwr),
		.srst_ctl_in(srs), .tck_in(tck), .tdi_in(tdi),
		.port_connected_out(conn), .port_enabled_out(pen),
		.srst_connected_out(sc), .tdo_out(tdo), .rise_count_out(rises));
	// ----------------------------------------
	// Clock, timeout and bus tasks
	// ----------------------------------------
	always #25 mclk_in = ~mclk_in;
	always @(posedge mclk_in) begin
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			close_out();
		end
	end
	task automatic close_out;
		$display("checks %0d mismatches %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : close_out
	task automatic xfer(input logic [11:0] a, input logic w,
		input logic [31:0] d, output logic [31:0] r);
		int n;
		n = 0;
		@(posedge mclk_in);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk_in);
		penable <= 1'b1;
		do begin
			@(posedge mclk_in);
			n++;
		end while (pready !== 1'b1 && n < 3000);
		if (n >= 3000) miscompares++;
		r = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : xfer
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] r;
		xfer(a, 1'b1, d, r);
	endtask : wr
	task automatic rd(input logic [11:0] a, output logic [31:0] r);
		xfer(a, 1'b0, 32'h0, r);
	endtask : rd
	task automatic push(input logic [11:0] a, input logic [31:0] d);
		logic [7:0] b;
		for (int i = 0; i <= int'(a[3:2]); i++) begin
			b = d[8*i +: 8];
			rq.push_back({b[6:0], carry});
			carry = b[7];
		end
		wr(a, d);
	endtask : push
	task automatic pull(input logic [11:0] a);
		logic [31:0] e, r;
		e = 32'h0;
		for (int i = 0; i <= int'(a[3:2]); i++) e[8*i +: 8] = rq.pop_front();
		rd(a, r);
		`CHK("response bytes", e, r)
	endtask : pull
	task automatic wait_idle;
		logic [31:0] r;
		for (int i = 0; i < 400; i++) begin
			rd(japr_pkg::OFS_CST, r);
			if (r[31:28] === 4'h0) break;
		end
	endtask : wait_idle
	task automatic blip(input logic [7:0] p);
		pwr <= p;
		@(posedge mclk_in);
		pwr <= 8'hff;
		repeat (4) @(posedge mclk_in);
	endtask : blip
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		logic [31:0] r;
		logic [11:0] adr [7] = '{12'hd00, 12'hd04, 12'hd08, 12'hdfc, 12'hefc,
			12'hf00, 12'hd0c};
		logic [31:0] rv [7] = '{32'hc, 32'h0, 32'h0,
			{REV, CONT, CODE, 17'h0}, 32'h0, 32'h0, 32'h0};
		repeat (20) @(posedge mclk_in);
		rstn_in <= 1'b1;
		for (int i = 0; i < 7; i++) begin
			rd(adr[i], r);
			`CHK("reset value", rv[i], r)
		end
		repeat (4) begin
			sel = 8'($random(seed));
			att <= 8'($random(seed));
			srs <= 8'($random(seed));
			wr(japr_pkg::OFS_SEL, {24'h0, sel});
			rd(japr_pkg::OFS_SEL, r);
			`CHK("select", {24'h0, sel}, r)
			rd(japr_pkg::OFS_CST, r);
			`CHK("attached", &(att | ~sel), r[3])
			`CHK("sysreset attached", &(srs | ~sel), r[2])
		end
		att <= 8'hfe;
		srs <= 8'hff;
		wr(japr_pkg::OFS_SEL, 32'h7);
		wr(japr_pkg::OFS_CST, 32'h3);
		repeat (20) @(posedge mclk_in);
		`CHK("test reset", 8'hf9, trst_n)
		`CHK("system reset", 8'hf9, sysr_n)
		att <= 8'hff;
		wr(japr_pkg::OFS_CST, 32'h0);
		@(posedge mclk_in);
		`CHK("released", 16'hffff, {trst_n, sysr_n})
		wr(japr_pkg::OFS_SEL, 32'h1);
		push(japr_pkg::OFS_BQ_FOUR, $random(seed));
		rd(japr_pkg::OFS_CST, r);
		`CHK("engine active", 1'b1, r[31])
		wait_idle();
		push(japr_pkg::OFS_BQ_THREE, $random(seed));
		wait_idle();
		`CHK("scan clocks", 56, rises)
		push(japr_pkg::OFS_BQ_ONE, $random(seed));
		repeat (150) @(posedge mclk_in);
		rd(japr_pkg::OFS_CST, r);
		`CHK("stalled", 8'h87, r[31:24])
		pull(japr_pkg::OFS_BQ_FOUR);
		pull(japr_pkg::OFS_BQ_THREE);
		wait_idle();
		pull(japr_pkg::OFS_BQ_ONE);
		rd(japr_pkg::OFS_CST, r);
		`CHK("drained", 8'h00, r[31:24])
		blip(8'hfe);
		rd(japr_pkg::OFS_FLT, r);
		`CHK("fault set", 32'h1, r)
		`CHK("faulted quiet", 3'h0, {tck[0], tms[0], tdi[0]})
		wr(japr_pkg::OFS_SEL, 32'h0);
		rd(japr_pkg::OFS_FLT, r);
		`CHK("fault kept", 32'h1, r)
		wr(japr_pkg::OFS_FLT, 32'h1);
		rd(japr_pkg::OFS_FLT, r);
		`CHK("fault cleared", 32'h0, r)
		wr(japr_pkg::OFS_ITM, 32'h1);
		wr(japr_pkg::OFS_SEL, 32'h1);
		blip(8'hfe);
		abort <= 1'b1;
		repeat (5) @(posedge mclk_in);
		rd(japr_pkg::OFS_FLT, r);
		`CHK("abort clears fault", 32'h0, r)
		rd(japr_pkg::OFS_ABT, r);
		`CHK("abort latched", 32'h1, r)
		rd(japr_pkg::OFS_ABT, r);
		`CHK("abort read clear", 32'h0, r)
		abort <= 1'b0;
		wr(japr_pkg::OFS_ITM, 32'h0);
		abort <= 1'b1;
		repeat (5) @(posedge mclk_in);
		wr(japr_pkg::OFS_ABT, 32'h1);
		rd(japr_pkg::OFS_ABT, r);
		`CHK("abort off", 32'h0, r)
		close_out();
	end
endmodule : test_jtag_access_port_regs
